/* File: rtl/srap_dev.sv */
// device end: serial register access port with a small register file
`timescale 1ns/1ps
module srap_dev
    import srap_pkg::*;
#(
    parameter int DEPTH = SRAP_REG_DEPTH
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    srap_if.dev              lnk,
    output logic             o_wr_pulse,
    output logic [14:0]      o_wr_addr,
    output logic [7:0]       o_wr_data,
    output logic             o_busy
);
    // three-stage samplers, change accepted when stages two and three agree
    logic [2:0]  sclk_s_ff;
    logic [2:0]  sel_s_ff;
    logic [2:0]  sdi_s_ff;
    logic        sclk_q_ff;
    logic        sel_q_ff;
    logic        sdi_q_ff;
    logic [4:0]  cnt_ff;
    logic [14:0] addr_ff;
    logic        rd_ff;
    logic        strm_ff;
    logic [7:0]  sh_ff;
    logic [7:0]  tx_ff;
    logic        oe_ff;
    logic        wpulse_ff;
    logic [14:0] waddr_ff;
    logic [7:0]  wdata_ff;
    logic [7:0]  mem_ff [DEPTH];

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sclk_s_ff <= 3'b000;
            sel_s_ff  <= 3'b111;
            sdi_s_ff  <= 3'b000;
            sclk_q_ff <= 1'b0;
            sel_q_ff  <= 1'b1;
            sdi_q_ff  <= 1'b0;
        end else begin
            sclk_s_ff <= {sclk_s_ff[1:0], lnk.sclk};
            sel_s_ff  <= {sel_s_ff[1:0], lnk.select_n_pin};
            sdi_s_ff  <= {sdi_s_ff[1:0], lnk.serial_in_pin};
            if (sclk_s_ff[1] == sclk_s_ff[2]) begin
                sclk_q_ff <= sclk_s_ff[2];
            end
            if (sel_s_ff[1] == sel_s_ff[2]) begin
                sel_q_ff <= sel_s_ff[2];
            end
            if (sdi_s_ff[1] == sdi_s_ff[2]) begin
                sdi_q_ff <= sdi_s_ff[2];
            end
        end
    end

    // sdi filtered by the same delay as sclk, so setup at the pin carries over
    wire         rise     = (sclk_s_ff[1] == sclk_s_ff[2]) && sclk_s_ff[2] && !sclk_q_ff;
    wire         fall     = (sclk_s_ff[1] == sclk_s_ff[2]) && !sclk_s_ff[2] && sclk_q_ff;
    wire         active   = !sel_q_ff;
    wire         sdi_now  = (sdi_s_ff[1] == sdi_s_ff[2]) ? sdi_s_ff[2] : sdi_q_ff;
    wire         bit_in   = rise && active;
    wire [7:0]   nxt_sh   = {sh_ff[6:0], sdi_now};
    wire         hdr_end  = bit_in && !strm_ff && (cnt_ff == 5'(SRAP_HDR_BITS - 1));
    wire         byte_end = bit_in && (strm_ff ? (cnt_ff[2:0] == 3'd7)
                                               : (cnt_ff == 5'(SRAP_FRAME_BITS - 1)));
    wire [7:0]   cfg_a    = mem_ff[SRAP_CFG_A_OFS[4:0]];
    wire [7:0]   ucfg     = mem_ff[SRAP_USER_CFG_OFS[4:0]];
    wire         asc      = cfg_a[SRAP_ASC_BIT_HI] | cfg_a[SRAP_ASC_BIT_LO];
    wire         hold     = ucfg[SRAP_HOLD_BIT];
    wire [14:0]  hdr_addr = {addr_ff[14:8], sh_ff[6:0], sdi_now};
    wire         in_map   = (addr_ff < 15'(DEPTH));
    wire [7:0]   rd_data  = (hdr_addr < 15'(DEPTH)) ? mem_ff[hdr_addr[4:0]] : 8'h00;
    wire [14:0]  nxt_addr = srap_step(addr_ff, asc, hold);
    // next streamed byte loaded on the fall, so output never moves while clock high
    wire [7:0]   cur_rd   = in_map ? mem_ff[addr_ff[4:0]] : 8'h00;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff    <= 5'h00;
            addr_ff   <= 15'h0000;
            rd_ff     <= 1'b0;
            strm_ff   <= 1'b0;
            sh_ff     <= 8'h00;
            tx_ff     <= 8'h00;
            oe_ff     <= 1'b0;
            wpulse_ff <= 1'b0;
            waddr_ff  <= 15'h0000;
            wdata_ff  <= 8'h00;
        end else begin
            wpulse_ff <= 1'b0;
            if (!active) begin
                cnt_ff  <= 5'h00;
                strm_ff <= 1'b0;
                oe_ff   <= 1'b0;
            end else if (bit_in) begin
                sh_ff  <= nxt_sh;
                cnt_ff <= byte_end ? 5'h00 : cnt_ff + 5'h01;
                if (!strm_ff && cnt_ff == 5'h00) begin
                    rd_ff <= sdi_now;
                end
                if (!strm_ff && cnt_ff == 5'h07) begin
                    addr_ff[14:8] <= nxt_sh[6:0];
                end
                if (!strm_ff && cnt_ff == 5'h0F) begin
                    addr_ff[7:0] <= nxt_sh;
                end
                if (hdr_end && rd_ff) begin
                    tx_ff <= rd_data;
                end
                if (byte_end) begin
                    strm_ff <= 1'b1;
                    addr_ff <= nxt_addr;
                    if (!rd_ff && in_map) begin
                        wpulse_ff <= 1'b1;
                        waddr_ff  <= addr_ff;
                        wdata_ff  <= nxt_sh;
                    end
                end
            end else if (fall) begin
                // data changes on falling edge, host samples on rising
                oe_ff <= rd_ff && (strm_ff || cnt_ff >= 5'(SRAP_HDR_BITS));
                if (oe_ff && cnt_ff != 5'h00) begin
                    tx_ff <= {tx_ff[6:0], 1'b0};
                end else if (rd_ff && strm_ff && cnt_ff == 5'h00) begin
                    tx_ff <= cur_rd;
                end
            end
        end
    end

    // mem write stays apart so a reset value per cell is set
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= SRAP_OTHER_RST;
            end
            mem_ff[SRAP_CFG_A_OFS[4:0]]    <= SRAP_CFG_A_RST;
            mem_ff[SRAP_USER_CFG_OFS[4:0]] <= SRAP_USER_CFG_RST;
        end else if (wpulse_ff) begin
            mem_ff[waddr_ff[4:0]] <= wdata_ff;
        end
    end

    assign lnk.serial_out_pin = oe_ff & tx_ff[7];
    assign lnk.serial_out_oe  = oe_ff;
    assign o_wr_pulse         = wpulse_ff;
    assign o_wr_addr          = waddr_ff;
    assign o_wr_data          = wdata_ff;
    assign o_busy             = active;
endmodule

/* File: include/srap_pkg.sv */
// package for the serial register access port: frame layout, register map, timing
// Behaviour
// - host holds select low through every access
// - device samples serial input on rising shift clock
// - plain access is exactly 24 bits
// - all fields shift most significant bit first
// - first bit one reads, zero writes
// - next fifteen bits carry register address
// - write stores last eight bits into register
// - read ignores last eight, returns register data
// - serial output driven only during read data
// - streaming continues data bytes while select low
// - address steps by one per further byte
// - direction bits at offset zero pick up/down
// - address-hold bit stops address stepping
// - host never accesses during converter calibration; the host checks i_cal_busy only before it starts a frame
// - multi-byte values least significant byte lowest
package srap_pkg;
    localparam int          SRAP_ADDR_W      = 15;
    localparam int          SRAP_DATA_W      = 8;
    localparam int          SRAP_HDR_BITS    = 16;
    localparam int          SRAP_FRAME_BITS  = 24;
    localparam int          SRAP_REG_DEPTH   = 32;
    // register offsets and field positions
    localparam logic [14:0] SRAP_CFG_A_OFS    = 15'h0000;
    localparam logic [14:0] SRAP_USER_CFG_OFS = 15'h0010;
    localparam int          SRAP_ASC_BIT_HI   = 5;
    localparam int          SRAP_ASC_BIT_LO   = 2;
    localparam int          SRAP_HOLD_BIT     = 0;
    localparam logic [7:0]  SRAP_CFG_A_RST    = 8'h3C;
    localparam logic [7:0]  SRAP_USER_CFG_RST = 8'h00;
    localparam logic [7:0]  SRAP_OTHER_RST    = 8'h00;
    // host shift clock: half period in reference clocks
    localparam int          SRAP_SCLK_HALF    = 16;
    typedef enum logic [1:0] {
        SRAP_H_IDLE = 2'b00,
        SRAP_H_LOW  = 2'b01,
        SRAP_H_HIGH = 2'b11,
        SRAP_H_DONE = 2'b10
    } srap_hstate_t;
    // step address up, down or not at all
    function automatic logic [14:0] srap_step(input logic [14:0] a, input logic asc,
                                              input logic hold);
        if (hold) begin
            return a;
        end else if (asc) begin
            return a + 15'h0001;
        end
        return a - 15'h0001;
    endfunction
endpackage

/* File: include/srap_if.sv */
// interface joining host and device of the serial register access port
`timescale 1ns/1ps
interface srap_if;
    logic sclk;
    logic select_n_pin;
    logic serial_in_pin;
    logic serial_out_pin;
    logic serial_out_oe;
    modport dev (
        input  sclk,
        input  select_n_pin,
        input  serial_in_pin,
        output serial_out_pin,
        output serial_out_oe
    );
    modport host (
        output sclk,
        output select_n_pin,
        output serial_in_pin,
        input  serial_out_pin,
        input  serial_out_oe
    );
endinterface

/* File: rtl/srap_host.sv */
// host end: drives frames on the serial register access port
`timescale 1ns/1ps
module srap_host
    import srap_pkg::*;
#(
    parameter int HALF = SRAP_SCLK_HALF
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    srap_if.host             lnk,
    input  wire logic        i_req,
    input  wire logic        i_rd,
    input  wire logic [14:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_more,
    input  wire logic        i_cal_busy,
    output logic             o_ready,
    output logic             o_byte_done,
    output logic [7:0]       o_rdata
);
    srap_hstate_t st_ff;
    logic [7:0]   div_ff;
    logic [4:0]   bit_ff;
    logic [23:0]  tx_ff;
    logic [7:0]   rx_ff;
    logic [7:0]   rdata_ff;
    logic         done_ff;
    logic         rd_ff;
    logic         strm_ff;
    logic [2:0]   sdo_s_ff;
    logic         sdo_q_ff;

    wire tick     = (div_ff == 8'(HALF - 1));
    wire last_bit = strm_ff ? (bit_ff[2:0] == 3'd7) : (bit_ff == 5'(SRAP_FRAME_BITS - 1));
    wire start    = i_req && !i_cal_busy;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sdo_s_ff <= 3'b000;
            sdo_q_ff <= 1'b0;
        end else begin
            sdo_s_ff <= {sdo_s_ff[1:0], lnk.serial_out_pin};
            if (sdo_s_ff[1] == sdo_s_ff[2]) begin
                sdo_q_ff <= sdo_s_ff[2];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_ff    <= SRAP_H_IDLE;
            div_ff   <= 8'h00;
            bit_ff   <= 5'h00;
            tx_ff    <= 24'h00_0000;
            rx_ff    <= 8'h00;
            rdata_ff <= 8'h00;
            done_ff  <= 1'b0;
            rd_ff    <= 1'b0;
            strm_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            div_ff  <= (st_ff == SRAP_H_IDLE || tick) ? 8'h00 : div_ff + 8'h01;
            case (st_ff)
                SRAP_H_IDLE: begin
                    if (start) begin
                        tx_ff   <= {i_rd, i_addr, i_wdata};
                        rd_ff   <= i_rd;
                        bit_ff  <= 5'h00;
                        strm_ff <= 1'b0;
                        st_ff   <= SRAP_H_LOW;
                    end
                end
                SRAP_H_LOW: begin
                    if (tick) begin
                        st_ff <= SRAP_H_HIGH;
                        rx_ff <= {rx_ff[6:0], sdo_q_ff};
                    end
                end
                SRAP_H_HIGH: begin
                    if (tick) begin
                        tx_ff  <= {tx_ff[22:0], 1'b0};
                        bit_ff <= last_bit ? 5'h00 : bit_ff + 5'h01;
                        st_ff  <= SRAP_H_LOW;
                        if (last_bit) begin
                            done_ff  <= 1'b1;
                            rdata_ff <= rx_ff;
                            strm_ff  <= 1'b1;
                            // further bytes: data in top byte, one per address step
                            tx_ff    <= {i_wdata, 16'h0000};
                            if (!i_more) begin
                                st_ff <= SRAP_H_DONE;
                            end
                        end
                    end
                end
                default: begin
                    if (tick) begin
                        st_ff <= SRAP_H_IDLE;
                    end
                end
            endcase
        end
    end

    assign lnk.sclk          = (st_ff == SRAP_H_HIGH);
    assign lnk.select_n_pin  = (st_ff == SRAP_H_IDLE) || (st_ff == SRAP_H_DONE);
    assign lnk.serial_in_pin = tx_ff[23];
    assign o_ready           = (st_ff == SRAP_H_IDLE) && !i_cal_busy;
    assign o_byte_done       = done_ff;
    assign o_rdata           = rdata_ff;
endmodule

/* File: bench/srap_asserts.sv */
// assertion checker watching the host-to-device link signals
`timescale 1ns/1ps
module srap_asserts (
    input  wire logic i_ref_clk,
    input  wire logic i_nrst,
    input  wire logic sclk,
    input  wire logic select_n_pin,
    input  wire logic serial_in_pin,
    input  wire logic serial_out_pin,
    input  wire logic serial_out_oe
);
    logic       sclk_d_ff;
    logic [7:0] rise_cnt_ff;
    wire        sclk_rise    = sclk & ~sclk_d_ff;
    // count cleared whenever select is high, so it always holds rises of this frame
    wire  [7:0] nxt_rise_cnt = select_n_pin ? 8'h00 : rise_cnt_ff + {7'h00, sclk_rise};
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sclk_d_ff   <= 1'b0;
            rise_cnt_ff <= 8'h00;
        end else begin
            sclk_d_ff   <= sclk;
            rise_cnt_ff <= nxt_rise_cnt;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_drive_window;
        serial_out_oe [*8];
    endsequence
    property p_idle_quiet;  select_n_pin [*8] |-> !serial_out_oe; endproperty
    property p_out_zero;    !serial_out_oe |-> !serial_out_pin; endproperty
    property p_oe_start;
        $rose(serial_out_oe) |-> !select_n_pin && !sclk && rise_cnt_ff == 8'h10;
    endproperty
    property p_oe_hold;     $rose(serial_out_oe) |-> s_drive_window; endproperty
    property p_out_on_fall;
        serial_out_oe && $past(serial_out_oe) && $changed(serial_out_pin) |-> !sclk;
    endproperty
    property p_clk_framed;  $changed(sclk) |-> !$past(select_n_pin); endproperty
    property p_frame_len;
        $rose(select_n_pin) |-> rise_cnt_ff >= 8'h18 && rise_cnt_ff[2:0] == 3'h0;
    endproperty
    property p_sdi_stable;  $rose(sclk) |-> $stable(serial_in_pin); endproperty
    property p_oe_end;      $rose(select_n_pin) |-> ##[1:8] !serial_out_oe; endproperty
    a_idle_quiet:  assert property (p_idle_quiet) else $error("output enabled while idle");
    a_out_zero:    assert property (p_out_zero) else $error("undriven output not low");
    a_oe_start:    assert property (p_oe_start) else $error("output enabled early");
    a_oe_hold:     assert property (p_oe_hold) else $error("output enable too short");
    a_out_on_fall: assert property (p_out_on_fall) else $error("data moved, clock high");
    a_clk_framed:  assert property (p_clk_framed) else $error("clock moved unselected");
    a_frame_len:   assert property (p_frame_len) else $error("frame length wrong");
    a_sdi_stable:  assert property (p_sdi_stable) else $error("data moved on rise");
    a_oe_end:      assert property (p_oe_end) else $error("output held after release");
endmodule

/* File: bench/serial_register_access_port_tb.sv */
// testbench joining host and device ends, plus a bench-driven second device
`timescale 1ns/1ps
module serial_register_access_port_tb;
    import srap_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_nrst    = 1'b0;
    logic        lclk      = 1'b0;
    logic        gate      = 1'b0;
    logic        req       = 1'b0;
    logic        rd        = 1'b0;
    logic        more      = 1'b0;
    logic        cal       = 1'b0;
    logic [14:0] addr      = 15'h0000;
    logic [7:0]  wdata     = 8'h00;
    logic        ready, bdone, wr_pulse, wr2, busy;
    logic [7:0]  rdata, wr_data, wd2;
    logic [14:0] wr_addr, wa2;
    logic [7:0]  bq [4];
    logic [7:0]  got [4];
    logic [14:0] wq [$];
    int          failures  = 0;
    int          n_checks  = 0;
    int          w2_n      = 0;
    srap_if lnk ();
    srap_if lnk2 ();
    // link clock of the bench device only runs inside frames
    assign lnk2.sclk = lclk & gate;
    srap_host i_srap_host (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .lnk(lnk), .i_req(req),
        .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_more(more), .i_cal_busy(cal),
        .o_ready(ready), .o_byte_done(bdone), .o_rdata(rdata));
    srap_dev i_srap_dev (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .lnk(lnk),
        .o_wr_pulse(wr_pulse), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_busy(busy));
    srap_dev i_srap_dev_b (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .lnk(lnk2),
        .o_wr_pulse(wr2), .o_wr_addr(wa2), .o_wr_data(wd2), .o_busy());
    srap_asserts i_srap_asserts (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .sclk(lnk.sclk),
        .select_n_pin(lnk.select_n_pin), .serial_in_pin(lnk.serial_in_pin),
        .serial_out_pin(lnk.serial_out_pin), .serial_out_oe(lnk.serial_out_oe));
    initial forever #2 i_ref_clk = ~i_ref_clk;
    // phase offset keeps every link clock edge off the reference clock edges
    initial begin
        #0.25;
        forever #62.5 lclk = ~lclk;
    end
    always @(posedge i_ref_clk) begin
        if (wr_pulse === 1'b1) wq.push_back(wr_addr);
        if (wr2 === 1'b1) w2_n++;
    end
    task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic xfer(input logic r, input logic [14:0] a, input int n);
        int k;
        rd = r;
        addr = a;
        wdata = bq[0];
        more = (n > 1);
        req = 1'b1;
        k = 0;
        while (ready !== 1'b1 && k < 100) begin
            tick(1);
            k++;
        end
        if (k >= 100) failures++;
        tick(1);
        req = 1'b0;
        wdata = bq[1];
        for (int i = 0; i < n; i++) begin
            k = 0;
            while (bdone !== 1'b1 && k < 2000) begin
                tick(1);
                k++;
            end
            if (k >= 2000) failures++;
            check("busy in frame", 15'(busy), 15'h0001);
            got[i] = rdata;
            more = (i + 2 < n);
            wdata = bq[(i + 2) % 4];
            tick(1);
        end
        // select rises with the last byte; host idles a half period later
        tick(SRAP_SCLK_HALF + 8);
        check("busy after frame", 15'(busy), 15'h0000);
    endtask
    task automatic check_wq(input int n, input logic [14:0] a0, a1, a2);
        logic [14:0] e [3];
        e = '{a0, a1, a2};
        check("write count", 15'(wq.size()), 15'(n));
        for (int i = 0; i < n; i++) check("write addr", wq[i], e[i]);
        wq.delete();
    endtask
    task automatic bang(input logic [23:0] v, input int n);
        @(negedge lclk);
        tick(1);
        lnk2.select_n_pin = 1'b0;
        gate = 1'b1;
        for (int i = 0; i < n; i++) begin
            lnk2.serial_in_pin = v[23 - i];
            @(negedge lclk);
            tick(1);
        end
        gate = 1'b0;
        lnk2.select_n_pin = 1'b1;
        lnk2.serial_in_pin = ~lnk2.serial_in_pin;
        repeat (4) @(negedge lclk);
        tick(1);
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        finish_test;
    end
    initial begin
        lnk2.select_n_pin = 1'b1;
        lnk2.serial_in_pin = 1'b0;
        bq = '{8'hA5, 8'h00, 8'h00, 8'h00};
        tick(4);
        i_nrst = 1'b1;
        check("oe after reset", 15'(lnk.serial_out_oe), 15'h0000);
        check("busy after reset", 15'(busy), 15'h0000);
        xfer(1'b0, 15'h0005, 1);
        check_wq(1, 15'h0005, 15'h0000, 15'h0000);
        check("write data", 15'(wr_data), 15'h00A5);
        xfer(1'b1, 15'h0005, 1);
        check("read 05", 15'(got[0]), 15'h00A5);
        xfer(1'b1, SRAP_CFG_A_OFS, 1);
        check("read cfg", 15'(got[0]), 15'(SRAP_CFG_A_RST));
        xfer(1'b1, 15'h0040, 1);
        check("read unmapped", 15'(got[0]), 15'h0000);
        check_wq(0, 15'h0000, 15'h0000, 15'h0000);
        bq = '{8'h11, 8'h22, 8'h33, 8'h00};
        xfer(1'b0, 15'h0008, 3);
        check_wq(3, 15'h0008, 15'h0009, 15'h000A);
        check("last stream data", 15'(wr_data), 15'h0033);
        xfer(1'b1, 15'h0008, 3);
        for (int i = 0; i < 3; i++) check("stream read", 15'(got[i]), 15'(bq[i]));
        bq = '{8'h00, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, SRAP_CFG_A_OFS, 1);
        bq = '{8'h44, 8'h55, 8'h00, 8'h00};
        wq.delete();
        xfer(1'b0, 15'h000C, 2);
        check_wq(2, 15'h000C, 15'h000B, 15'h0000);
        bq = '{8'h04, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, SRAP_CFG_A_OFS, 1);
        wq.delete();
        xfer(1'b0, 15'h000E, 2);
        check_wq(2, 15'h000E, 15'h000F, 15'h0000);
        bq = '{8'h01, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, SRAP_USER_CFG_OFS, 1);
        bq = '{8'h66, 8'h77, 8'h00, 8'h00};
        wq.delete();
        xfer(1'b0, 15'h0014, 2);
        check_wq(2, 15'h0014, 15'h0014, 15'h0000);
        xfer(1'b1, 15'h0014, 1);
        check("held read", 15'(got[0]), 15'h0077);
        cal = 1'b1;
        req = 1'b1;
        tick(100);
        check("ready in cal", 15'(ready), 15'h0000);
        check("select in cal", 15'(lnk.select_n_pin), 15'h0001);
        req = 1'b0;
        cal = 1'b0;
        bang({1'b0, 15'h0003, 8'h5A}, 12);
        check("partial frame", 15'(w2_n), 15'h0000);
        bang({1'b0, 15'h0003, 8'h5A}, 24);
        check("bench write", 15'(w2_n), 15'h0001);
        check("bench addr", wa2, 15'h0003);
        check("bench data", 15'(wd2), 15'h005A);
        finish_test;
    end
endmodule
